// File: hdl/extbc_pkg.sv
// shared constants, carrier types and decode functions of the bus controller
package extbc_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_WIN = 4;
  localparam int NUM_CS = 5;
  localparam int CS_IDX_W = 3;
  localparam int SEG_LO = 16;
  localparam int WIN_LO = 12;
  localparam int BUS_DIV_DEF = 2;
  localparam logic [7:0] IPB_SEG_DEF = 8'h20;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] addrPhase;
    logic [3:0] waitCyc;
    logic [1:0] holdCyc;
  } extbc_timing_type;

  typedef struct packed {
    logic enable;
    logic bus16;
    logic muxed;
    logic readyEn;
    logic readyHigh;
  } extbc_func_type;

  typedef struct packed {
    extbc_timing_type timing;
    extbc_func_type func;
  } extbc_cs_cfg_type;

  typedef struct packed {
    logic enable;
    logic [11:0] base;
    logic [3:0] size;
  } extbc_win_sel_type;

  typedef struct packed {
    logic [23:0] addr;
    logic write;
    logic word;
    logic [15:0] wdata;
  } extbc_req_type;

  typedef struct packed {
    logic sel;
    logic [23:0] addr;
    logic write;
    logic word;
    logic [15:0] wdata;
  } extbc_ipb_type;

  typedef struct packed {
    logic [15:0] ad;
    logic adOe;
    logic [23:0] addr;
    logic ale;
    logic rdN;
    logic wrN;
    logic [4:0] csN;
  } extbc_pin_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_ADDR,
    ST_CMD,
    ST_READY,
    ST_HOLD,
    ST_DONE
  } extbc_state_type;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [12:0] CFG_RST = 13'h09bc;
  localparam logic [4:0] CS_OFF = 5'h1f;
  localparam extbc_pin_type PIN_RST = '{ad: 16'h0000, adOe: 1'b0,
    addr: 24'h000000, ale: 1'b0, rdN: 1'b1, wrN: 1'b1, csN: 5'h1f};
  localparam extbc_ipb_type IPB_RST = '{sel: 1'b0, addr: 24'h000000,
    write: 1'b0, word: 1'b0, wdata: 16'h0000};

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic winMatch(input logic [23:0] a,
                                    input extbc_win_sel_type w);
    logic [11:0] m;
    m = 12'hfff << w.size;
    return w.enable && ((a[23:12] & m) == (w.base & m));
  endfunction

  // window 4 over 3, 2 over 1; upper pair also beats lower pair
  function automatic logic [2:0] csPick(input logic [3:0] m);
    if (m[3]) return 3'h4;
    if (m[2]) return 3'h3;
    if (m[1]) return 3'h2;
    if (m[0]) return 3'h1;
    return 3'h0;
  endfunction

endpackage

// File: hdl/extbc_cfg_mem.sv
// per-chip-select timing and function configuration store
`timescale 1ns/1ns
module extbc_cfg_mem
  import extbc_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 5,
  parameter int IDX_W = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic we,
  input wire logic [IDX_W-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [IDX_W-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [WIDTH-1:0] rdDataReg;

  // every entry starts at the default so cs0 works straight from reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        memReg[i] <= RST_VAL;
      end
      rdDataReg <= RST_VAL;
    end else if (ce) begin
      if (we && (int'(wrIdx) < DEPTH)) begin
        memReg[wrIdx] <= wrData;
      end
      rdDataReg <= (int'(rdIdx) < DEPTH) ? memReg[rdIdx] : RST_VAL;
    end
  end

  assign rdData = rdDataReg;

endmodule

// File: hdl/extbc_core.sv
// external bus controller: window decode, bus sequencer, pin drivers
//
// Contract
// - Every off-chip access and internal peripheral bus access runs here.
// - Internal peripheral bus accesses use the same sequencer as external.
// - Single-chip mode or external bus mode is selectable.
// - Address bus width programmable from zero to twenty-three bits.
// - External data bus is eight or sixteen bits wide.
// - Multiplexed or demultiplexed bus operation selectable.
// - Demultiplexed mode puts low address on dedicated address lines.
// - Segment line count selectable, space 8 Mbytes down to 64 Kbytes.
// - Active-low chip selects, one per window plus the default.
// - Timing and function settings are programmable per chip select.
// - Ready input stretches accesses; its active level is programmable.
// - Up to four address windows, each with own bus characteristics.
// - Window 4 beats window 3, window 2 beats window 1.
// - Accesses outside all windows use chip select zero settings.
// - Only the matching window may assert its chip select.
// - Bus timing follows rising edge of the driven reference clock.
// - Bus mode, width and multiplexing switch per access by window.
// - Reserved map regions become external bus accesses.
`timescale 1ns/1ns
module extbc_core
  import extbc_pkg::*;
#(
  parameter int BUS_DIV = BUS_DIV_DEF,
  parameter logic [7:0] IPB_SEG = IPB_SEG_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic singleChip,
  input wire logic [4:0] addrBusWidth,
  input wire logic [2:0] segLineCount,
  input wire extbc_win_sel_type [NUM_WIN-1:0] winSel,
  input wire logic cfgWe,
  input wire logic [CS_IDX_W-1:0] cfgIdx,
  input wire extbc_cs_cfg_type cfgData,
  input wire logic reqValid,
  input wire extbc_req_type req,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output extbc_ipb_type ipbOut,
  input wire logic [DATA_W-1:0] ipbRdata,
  input wire logic ipbReady,
  output logic busClkOut,
  output extbc_pin_type busPins,
  input wire logic [DATA_W-1:0] adIn,
  input wire logic readyPin
);

  localparam int DIV_W = (BUS_DIV > 2) ? $clog2(BUS_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BUS_DIV / 2);

  extbc_state_type stateReg, stateNext;
  logic [3:0] cntReg, cntNext;
  logic startedReg, startedNext;
  logic byteHiReg, byteHiNext;
  extbc_req_type reqReg, reqNext;
  logic ipbHitReg, ipbHitNext;
  logic [2:0] csIdxReg, csIdxNext;
  logic [15:0] rdataReg, rdataNext;
  logic reqReadyReg, reqReadyNext;
  logic rspValidReg, rspValidNext;
  logic [15:0] rspDataReg, rspDataNext;
  extbc_pin_type pinsReg, pinsNext;
  extbc_ipb_type ipbReg, ipbNext;
  logic [DIV_W-1:0] divCntReg, divCntNext;
  logic busClkReg;
  logic rdyS1Reg, rdyS2Reg, rdyS3Reg, rdyStableReg;
  logic [12:0] cfgRaw;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [NUM_WIN-1:0] winHit;
  logic [ADDR_W-1:0] addrMask;
  logic ipbHitNow;
  logic take;
  logic busEdge;
  extbc_cs_cfg_type cfg;
  logic readyOk;
  logic readyGo;
  logic [23:0] curAddr;
  logic [15:0] wrData;
  logic [15:0] dataIn;
  logic [4:0] csOn;
  logic needSecond;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++) begin : g_win
      assign winHit[gi] = winMatch(req.addr, winSel[gi]);
    end
    for (gi = 0; gi < ADDR_W; gi++) begin : g_mask
      if (gi < SEG_LO) begin : g_lo
        assign addrMask[gi] = 5'(gi) < addrBusWidth;
      end else begin : g_seg
        // A23 never carries: the segment lines top out at 8 Mbytes
        assign addrMask[gi] = (5'(gi) < addrBusWidth) &&
                              (3'(gi - SEG_LO) < segLineCount);
      end
    end
  endgenerate

  // anything off the peripheral segment goes out, reserved areas too
  assign ipbHitNow = req.addr[23:16] == IPB_SEG;
  assign take = (stateReg == ST_IDLE) && reqValid && reqReadyReg;
  assign busEdge = divCntReg == DIV_LAST;
  assign divCntNext = busEdge ? '0 : divCntReg + 1'b1;
  assign cfg = extbc_cs_cfg_type'(cfgRaw);
  assign readyOk = rdyStableReg == cfg.func.readyHigh;
  assign readyGo = ipbHitReg ? ipbReady :
                   (!cfg.func.readyEn || readyOk);
  assign curAddr = {reqReg.addr[23:1], reqReg.addr[0] | byteHiReg};
  assign wrData = cfg.func.bus16 ?
                  (reqReg.word ? reqReg.wdata :
                   {reqReg.wdata[7:0], reqReg.wdata[7:0]}) :
                  {8'h00, byteHiReg ? reqReg.wdata[15:8] :
                   reqReg.wdata[7:0]};
  assign dataIn = ipbHitReg ? ipbRdata : adIn;
  assign csOn = cfg.func.enable ? ~(5'h01 << csIdxReg) : CS_OFF;
  assign needSecond = reqReg.word && !cfg.func.bus16 &&
                      !byteHiReg && !ipbHitReg;

  // ---------------------------------------------------------------
  // configuration store, read by the latched chip select index
  // ---------------------------------------------------------------
  extbc_cfg_mem #(
    .WIDTH(13),
    .DEPTH(NUM_CS),
    .IDX_W(CS_IDX_W),
    .RST_VAL(CFG_RST)
  ) u_cfg (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .we(cfgWe),
    .wrIdx(cfgIdx),
    .wrData(cfgData),
    .rdIdx(csIdxReg),
    .rdData(cfgRaw)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    startedNext = startedReg;
    byteHiNext = byteHiReg;
    reqNext = reqReg;
    ipbHitNext = ipbHitReg;
    csIdxNext = csIdxReg;
    rdataNext = rdataReg;
    reqReadyNext = reqReadyReg;
    rspValidNext = 1'b0;
    rspDataNext = rspDataReg;
    pinsNext = pinsReg;
    ipbNext = ipbReg;
    case (stateReg)
      ST_IDLE: begin
        if (take) begin
          reqNext = req;
          ipbHitNext = ipbHitNow;
          csIdxNext = csPick(winHit);
          reqReadyNext = 1'b0;
          byteHiNext = 1'b0;
          rdataNext = 16'h0000;
          // no pins move in single-chip mode
          stateNext = (singleChip && !ipbHitNow) ?
                      ST_DONE : ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        startedNext = 1'b0;
        stateNext = ST_ADDR;
      end
      ST_ADDR: begin
        if (busEdge) begin
          if (!startedReg) begin
            startedNext = 1'b1;
            cntNext = {2'h0, cfg.timing.addrPhase};
            if (ipbHitReg) begin
              ipbNext = '{sel: 1'b1, addr: reqReg.addr,
                write: reqReg.write, word: reqReg.word,
                wdata: reqReg.wdata};
            end else begin
              pinsNext.addr = curAddr & addrMask;
              pinsNext.ad = curAddr[15:0];
              pinsNext.adOe = cfg.func.muxed;
              pinsNext.ale = 1'b1;
              pinsNext.csN = csOn;
            end
          end else if (cntReg != 4'h0) begin
            cntNext = cntReg - 4'h1;
          end else begin
            pinsNext.ale = 1'b0;
            if (!ipbHitReg) begin
              pinsNext.rdN = reqReg.write;
              pinsNext.wrN = !reqReg.write;
              pinsNext.ad = reqReg.write ? wrData : pinsReg.ad;
              pinsNext.adOe = reqReg.write;
            end
            cntNext = cfg.timing.waitCyc;
            stateNext = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (busEdge) begin
          if (cntReg != 4'h0) begin
            cntNext = cntReg - 4'h1;
          end else begin
            stateNext = ST_READY;
          end
        end
      end
      ST_READY: begin
        if (busEdge && readyGo) begin
          if (ipbHitReg || cfg.func.bus16) begin
            rdataNext = reqReg.word ? dataIn :
                        {8'h00, reqReg.addr[0] ? dataIn[15:8] :
                         dataIn[7:0]};
          end else if (byteHiReg) begin
            rdataNext[15:8] = dataIn[7:0];
          end else begin
            rdataNext[7:0] = dataIn[7:0];
          end
          pinsNext.rdN = 1'b1;
          pinsNext.wrN = 1'b1;
          cntNext = {2'h0, cfg.timing.holdCyc};
          stateNext = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (busEdge) begin
          if (cntReg != 4'h0) begin
            cntNext = cntReg - 4'h1;
          end else begin
            pinsNext = PIN_RST;
            ipbNext.sel = 1'b0;
            if (needSecond) begin
              // word on a byte bus: high byte follows at odd address
              byteHiNext = 1'b1;
              startedNext = 1'b0;
              stateNext = ST_ADDR;
            end else begin
              stateNext = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        rspValidNext = 1'b1;
        rspDataNext = rdataReg;
        reqReadyNext = 1'b1;
        stateNext = ST_IDLE;
      end
      default: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stateReg <= ST_IDLE;
      cntReg <= 4'h0;
      startedReg <= 1'b0;
      byteHiReg <= 1'b0;
      reqReg <= '0;
      ipbHitReg <= 1'b0;
      csIdxReg <= 3'h0;
      rdataReg <= 16'h0000;
      reqReadyReg <= 1'b1;
      rspValidReg <= 1'b0;
      rspDataReg <= 16'h0000;
    end else if (ce) begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      startedReg <= startedNext;
      byteHiReg <= byteHiNext;
      reqReg <= reqNext;
      ipbHitReg <= ipbHitNext;
      csIdxReg <= csIdxNext;
      rdataReg <= rdataNext;
      reqReadyReg <= reqReadyNext;
      rspValidReg <= rspValidNext;
      rspDataReg <= rspDataNext;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinsReg <= PIN_RST;
      ipbReg <= IPB_RST;
    end else if (ce) begin
      pinsReg <= pinsNext;
      ipbReg <= ipbNext;
    end
  end

  // ---------------------------------------------------------------
  // reference clock divider and ready synchroniser
  // ---------------------------------------------------------------
  // pins and the clock rise in the same ref_clk edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCntReg <= '0;
      busClkReg <= 1'b0;
    end else if (ce) begin
      divCntReg <= divCntNext;
      busClkReg <= divCntNext < DIV_HALF;
    end
  end

  // third stage filters a one-cycle glitch from the pin
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdyS1Reg <= 1'b0;
      rdyS2Reg <= 1'b0;
      rdyS3Reg <= 1'b0;
      rdyStableReg <= 1'b0;
    end else if (ce) begin
      rdyS1Reg <= readyPin;
      rdyS2Reg <= rdyS1Reg;
      rdyS3Reg <= rdyS2Reg;
      if (rdyS2Reg == rdyS3Reg) begin
        rdyStableReg <= rdyS3Reg;
      end
    end
  end

  assign reqReady = reqReadyReg;
  assign rspValid = rspValidReg;
  assign rspData = rspDataReg;
  assign ipbOut = ipbReg;
  assign busClkOut = busClkReg;
  assign busPins = pinsReg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  single_chip_idle_a: assert property (
    take && ce && singleChip && !ipbHitNow |=> stateReg == ST_DONE
    ##1 rspValidReg && rspDataReg == 16'h0000 && pinsReg.csN == CS_OFF)
    else $error("single-chip access drove the bus");

  cs_only_match_a: assert property (
    pinsReg.csN != CS_OFF |->
    $onehot(~pinsReg.csN) && !pinsReg.csN[csIdxReg])
    else $error("chip select not the matching window");

  win_top_prio_a: assert property (
    take && ce && winHit[3] |=> csIdxReg == 3'h4)
    else $error("window 4 lost priority");

  win_low_prio_a: assert property (
    take && ce && winHit[1] && winHit[3:2] == 2'h0 |=> csIdxReg == 3'h2)
    else $error("window 2 lost priority");

  default_window_a: assert property (
    take && ce && winHit == 4'h0 |=> csIdxReg == 3'h0)
    else $error("unmatched access not on default select");

  ready_wait_a: assert property (
    ce && stateReg == ST_READY && busEdge && !ipbHitReg &&
    cfg.func.readyEn && !readyOk |=> stateReg == ST_READY && !pinsReg.rdN
    | !pinsReg.wrN)
    else $error("access ended while ready inactive");

  ready_done_a: assert property (
    ce && stateReg == ST_READY && busEdge && !ipbHitReg &&
    (!cfg.func.readyEn || readyOk) |=> stateReg == ST_HOLD && pinsReg.rdN
    && pinsReg.wrN)
    else $error("active ready did not end the strobe");

  pins_on_edge_a: assert property (
    $changed(pinsReg) |-> busClkReg && !$past(busClkReg))
    else $error("pins moved off the reference clock rise");

  ipb_path_a: assert property (disable iff (!rstn || !ce)
    take && ipbHitNow |-> ##[2:9] ipbReg.sel && pinsReg.csN == CS_OFF)
    else $error("peripheral access not on internal bus");

  addr_width_a: assert property (
    $stable(addrBusWidth) && $stable(segLineCount) |->
    (pinsReg.addr & ~addrMask) == 24'h000000)
    else $error("address line beyond programmed width");

  mux_addr_a: assert property (
    pinsReg.ale |-> pinsReg.adOe == cfg.func.muxed)
    else $error("address phase drive mismatches mode");

endmodule

// File: verif/extbc_ext_mem.sv
// behavioural external memory answering the bus pins
`timescale 1ns/1ns
module extbc_ext_mem
  import extbc_pkg::*;
(
  input wire logic ref_clk,
  input wire extbc_pin_type pins,
  input wire logic rdyHigh,
  input wire logic [4:0] rdyDelay,
  output logic [15:0] adIn,
  output logic readyPin,
  output logic [23:0] seenAddr_reg,
  output logic [15:0] seenAle_reg,
  output logic [15:0] seenData_reg,
  output logic [4:0] seenCs_reg
);
  // --------
  // read data and ready
  // --------
  logic [15:0] adHold_reg = 16'h0000;
  logic [4:0] cmdCnt_reg = 5'h00;
  wire logic cmdOn = !pins.rdN || !pins.wrN;
  wire logic [15:0] rdVal = pins.addr[15:0] ^ 16'h5a3c;
  // released lines toggle, so a capture one cycle late never matches
  assign adIn = pins.rdN ? ~adHold_reg : rdVal;
  // slow device: ready turns active a set time into the command
  assign readyPin = (cmdOn && cmdCnt_reg >= rdyDelay) ? rdyHigh
    : !rdyHigh;
  always_ff @(posedge ref_clk) begin
    adHold_reg <= adIn;
    if (!cmdOn) cmdCnt_reg <= 5'h00;
    else if (cmdCnt_reg != 5'h1f) cmdCnt_reg <= cmdCnt_reg + 5'h01;
    if (pins.ale && pins.adOe) seenAle_reg <= pins.ad;
    if (cmdOn) seenAddr_reg <= pins.addr;
    if (cmdOn) seenCs_reg <= pins.csN;
    if (!pins.wrN && pins.adOe) seenData_reg <= pins.ad;
  end
endmodule

// File: verif/tb_extbc_core.sv
// self-checking bench of the external bus controller
`timescale 1ns/1ns
module tb_extbc_core
  import extbc_pkg::*;
;
  // --------
  // signals
  // --------
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic singleChip = 1'h0;
  logic [4:0] addrBusWidth = 5'h18;
  logic [2:0] segLineCount = 3'h7;
  extbc_win_sel_type [NUM_WIN-1:0] winSel = '{'{1'h1, 12'h300, 4'h0},
    '{1'h1, 12'h300, 4'h4}, '{1'h1, 12'h100, 4'h0}, '{1'h1, 12'h100, 4'h4}};
  logic cfgWe = 1'h0;
  logic [CS_IDX_W-1:0] cfgIdx = 3'h0;
  extbc_cs_cfg_type cfgData = CFG_RST;
  logic reqValid = 1'h0;
  extbc_req_type req = '0;
  logic ipbReady = 1'h0;
  logic rdyHigh = 1'h0;
  logic [4:0] rdyDelay = 5'h00;
  logic reqReady, rspValid, busClkOut, readyPin;
  logic [DATA_W-1:0] rspData, adIn;
  extbc_ipb_type ipbOut;
  extbc_pin_type busPins, prevPins;
  logic prevClk = 1'h0;
  logic csSeen = 1'h0;
  logic [23:0] ipbAddr, seenAddr_reg;
  logic [15:0] seenAle_reg, seenData_reg;
  logic [4:0] seenCs_reg;
  int err_total = 0;
  int compares = 0;
  int lat;

  extbc_core extbc_core_i (.ref_clk, .rstn, .ce(1'h1), .singleChip,
    .addrBusWidth, .segLineCount, .winSel, .cfgWe, .cfgIdx, .cfgData,
    .reqValid, .req, .reqReady, .rspValid, .rspData, .ipbOut,
    .ipbRdata(16'h77e1), .ipbReady, .busClkOut, .busPins, .adIn, .readyPin);
  extbc_ext_mem extbc_ext_mem_i (.ref_clk, .pins(busPins), .rdyHigh,
    .rdyDelay, .adIn, .readyPin, .seenAddr_reg, .seenAle_reg,
    .seenData_reg, .seenCs_reg);

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  // --------
  // shared tasks
  // --------
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // request held until the taking edge, then released
  task automatic acc(input logic [23:0] a, input logic wr, input logic wd,
                     input logic [15:0] d);
    while (reqReady !== 1'h1) @(negedge ref_clk);
    req = '{addr: a, write: wr, word: wd, wdata: d};
    reqValid = 1'h1;
    @(negedge ref_clk);
    reqValid = 1'h0;
    lat = 0;
    while (rspValid !== 1'h1 && lat < 400) begin
      @(negedge ref_clk);
      lat++;
    end
    chk("rspValid", 1'h1, rspValid);
  endtask

  task automatic cfg(input logic [2:0] i, input logic [3:0] wc,
                     input extbc_func_type f);
    cfgIdx = i;
    cfgData = '{timing: '{2'h1, wc, 2'h1}, func: f};
    cfgWe = 1'h1;
    @(negedge ref_clk);
    cfgWe = 1'h0;
  endtask

  // pins may only move together with the reference clock rising
  always @(negedge ref_clk) begin
    if (rstn) begin
      chk("pinEdge", 1'h1,
        busPins === prevPins || (busClkOut && !prevClk));
      chk("oneCs", 1'h1, $countones(~busPins.csN) <= 1);
    end
    if (busPins.csN !== 5'h1f) csSeen = 1'h1;
    if (ipbOut.sel) ipbAddr = ipbOut.addr;
    ipbReady <= ipbOut.sel;
    prevPins = busPins;
    prevClk = busClkOut;
  end

  // --------
  // scenarios
  // --------
  task automatic tReset();
    chk("reqReady", 1'h1, reqReady);
    chk("rspValid", 1'h0, rspValid);
    chk("csN", 5'h1f, busPins.csN);
    chk("rdwrN", 1'h1, busPins.rdN & busPins.wrN);
  endtask

  task automatic tWindows();
    logic [23:0] at [6];
    logic [4:0] cs [6];
    at = '{24'h101000, 24'h100010, 24'h301000, 24'h300020, 24'h050000,
      24'h00f300};
    cs = '{5'h1d, 5'h1b, 5'h17, 5'h0f, 5'h1e, 5'h1e};
    for (int i = 0; i < 6; i++) begin
      acc(at[i], 1'h0, 1'h1, 16'h0000);
      chk("csN", cs[i], seenCs_reg);
      chk("rspData", at[i][15:0] ^ 16'h5a3c, rspData);
      chk("adAddr", at[i][15:0], seenAle_reg);
      chk("latency", 1'h1, lat >= 18 && lat <= 23);
    end
  endtask

  task automatic tTiming();
    for (int w = 0; w < 8; w += 7) begin
      cfg(3'h0, w[3:0], 5'h1c);
      acc(24'h050000, 1'h0, 1'h1, 16'h0000);
      chk("latency", 1'h1,
        lat >= 2 * (6 + w) && lat <= 2 * (6 + w) + 5);
    end
    cfg(3'h0, 4'h3, 5'h1c);
  endtask

  // the device holds ready inactive for 20 cycles of the command
  task automatic tReady();
    for (int h = 0; h < 2; h++) begin
      rdyHigh = h[0];
      rdyDelay = 5'h14;
      cfg(3'h0, 4'h3, {4'hf, h[0]});
      acc(24'h050000, 1'h0, 1'h1, 16'h0000);
      chk("readyWait", 1'h1, lat > 26);
      chk("rspData", 16'h5a3c, rspData);
    end
    rdyDelay = 5'h00;
    cfg(3'h0, 4'h3, 5'h1c);
  endtask

  task automatic tDynamic();
    cfg(3'h1, 4'h3, 5'h10);
    acc(24'h101002, 1'h0, 1'h1, 16'h0000);
    chk("rspData", 16'h3f3e, rspData);
    chk("addrPins", 24'h101003, seenAddr_reg);
    acc(24'h100011, 1'h0, 1'h0, 16'h0000);
    chk("byteLane", 8'h5a, rspData[7:0]);
    acc(24'h100020, 1'h1, 1'h1, 16'hc3a5);
    chk("wrData", 16'hc3a5, seenData_reg);
    cfg(3'h1, 4'h3, 5'h1c);
  endtask

  task automatic tWidth();
    addrBusWidth = 5'h10;
    acc(24'h050004, 1'h0, 1'h1, 16'h0000);
    chk("addrPins", 24'h000004, seenAddr_reg);
    addrBusWidth = 5'h18;
    segLineCount = 3'h2;
    acc(24'h050004, 1'h0, 1'h1, 16'h0000);
    chk("addrPins", 24'h010004, seenAddr_reg);
    segLineCount = 3'h7;
  endtask

  task automatic tSingle();
    singleChip = 1'h1;
    csSeen = 1'h0;
    acc(24'h050000, 1'h0, 1'h1, 16'h0000);
    chk("rspData", 16'h0000, rspData);
    chk("latency", 1'h1, lat == 1);
    acc(24'h200100, 1'h0, 1'h1, 16'h0000);
    chk("ipbData", 16'h77e1, rspData);
    chk("ipbAddr", 24'h200100, ipbAddr);
    chk("csSeen", 1'h0, csSeen);
    singleChip = 1'h0;
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    tReset();
    rstn = 1'h1;
    @(negedge ref_clk);
    tWindows();
    tTiming();
    tReady();
    tDynamic();
    tWidth();
    tSingle();
    summarize();
  end

  // 17 accesses of under 60 cycles each; generous margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    summarize();
  end
endmodule
